// >>> rtl/dsp_sram_port.sv
// double-data-rate two-word burst sram: pin interface and storage array
// assumes the controller drives pins synchronous to link_clk and its
// complement is the low phase of link_clk; clk is an unrelated system clock
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - addresses taken on alternate rising edges only
// - write words taken on rising, complement edges
// - read words launched on rising, complement edges
// - one address selects a two-word burst
// - array depth set by word width configuration
// - latency select high gives 2.5 cycle reads
// - latency select low gives one cycle reads
// - read valid marks data on the bus
// - echo outputs aligned with read data
// - inputs and outputs pass through edge registers
// - array write completes without controller sequencing
// - shared data bus driven only for reads
module dsp_sram_port #(
    parameter int WORD_W = dsp_pkg::WORD_W_NARROW,
    parameter int ADDR_W = (WORD_W == dsp_pkg::WORD_W_NARROW) ?
                           dsp_pkg::ADDR_W_NARROW : dsp_pkg::ADDR_W_WIDE
) (
    input  wire logic                clk,              // system clock, 200 MHz
    input  wire logic                arst_n,           // asynchronous reset, active low
    input  wire logic                link_clk,         // primary timing input from controller
    input  wire logic                load_n,           // command present, active low
    input  wire logic                read_nwrite,      // 1 read, 0 write
    input  wire logic [ADDR_W-1:0]   addr,             // word-pair address
    input  wire logic [WORD_W/dsp_pkg::LANE_W-1:0] byte_lane_mask_n, // lane write mask, low writes
    input  wire logic [WORD_W-1:0]   dq_in,            // shared data bus, received level
    output logic [WORD_W-1:0]        dq_out,           // shared data bus, driven value
    output logic                     dq_oe,            // shared bus output enable, high drives
    output logic                     read_valid_flag,  // read data valid on the bus
    output logic                     echo_timing_out,  // echo timing output
    output logic                     echo_timing_out_n,// complementary echo output
    input  wire logic                latency_select,   // high 2.5 cycle, low 1 cycle reads
    output logic                     cmd_seen,         // one clk pulse per accepted command
    output logic                     rd_seen,          // one clk pulse per accepted read
    output logic                     lat_long          // latency select seen in clk domain
);
    import dsp_pkg::*;

    localparam int LANES = WORD_W / LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // refuse geometries the lane logic and array cannot serve
    initial begin
        if (WORD_W != WORD_W_NARROW && WORD_W != WORD_W_WIDE) begin
            $error("word width must be the narrow or the wide configuration");
        end
        if (ADDR_W < 1 || ADDR_W > ADDR_W_NARROW) begin
            $error("address width out of range");
        end
        if (WORD_W == WORD_W_WIDE && ADDR_W > ADDR_W_WIDE) begin
            $error("address width too large for the wide configuration");
        end
    end

    // link-domain reset: asserted at once, released on link_clk
    logic k_rst_n;
    dsp_sync2 #(.RST_VAL(RST_LOW)) u_k_rst (
        .clk    (link_clk),
        .arst_n (arst_n),
        .d      (RST_HIGH),
        .q      (k_rst_n)
    );

    // latency select is a static strap, crossed into the link domain
    logic lat_hi;
    dsp_sync2 #(.RST_VAL(RST_LOW)) u_k_lat (
        .clk    (link_clk),
        .arst_n (arst_n),
        .d      (latency_select),
        .q      (lat_hi)
    );

    // input registers on the rising edge
    logic              load_n_r;
    logic              rnw_r;
    logic [ADDR_W-1:0] addr_r;
    always_ff @(posedge link_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            load_n_r <= RST_HIGH;
            rnw_r    <= RST_HIGH;
            addr_r   <= '0;
        end else begin
            load_n_r <= load_n;
            rnw_r    <= read_nwrite;
            addr_r   <= addr;
        end
    end

    // command decode from the registered pins
    dsp_cmd_t   cmd;
    dsp_phase_t phase_r;
    logic       acc_rd;
    logic       acc_wr;
    always_comb begin
        cmd = DSP_CMD_NOP;
        if (!load_n_r) begin
            cmd = rnw_r ? DSP_CMD_READ : DSP_CMD_WRITE;
        end
    end
    assign acc_rd = (phase_r == DSP_PH_ADDR) && (cmd == DSP_CMD_READ);
    assign acc_wr = (phase_r == DSP_PH_ADDR) && (cmd == DSP_CMD_WRITE);

    // phase: a taken address blocks the next rising edge
    always_ff @(posedge link_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            phase_r <= DSP_PH_ADDR;
        end else begin
            case (phase_r)
                DSP_PH_ADDR: begin
                    if (cmd != DSP_CMD_NOP) begin
                        phase_r <= DSP_PH_DATA;
                    end
                end
                DSP_PH_DATA: begin
                    phase_r <= DSP_PH_ADDR;
                end
                default: begin
                    phase_r <= DSP_PH_ADDR;
                end
            endcase
        end
    end

    // storage: one array per burst position, indexed by word pair
    logic [WORD_W-1:0] mem_first  [DEPTH];
    logic [WORD_W-1:0] mem_second [DEPTH];

    // write data input registers, rising and complement edge
    logic [WORD_W-1:0] wd0_r;
    logic [LANES-1:0]  wm0_r;
    logic [WORD_W-1:0] wd1_r;
    logic [LANES-1:0]  wm1_r;
    always_ff @(posedge link_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            wd0_r <= '0;
            wm0_r <= '1;
        end else begin
            wd0_r <= dq_in;
            wm0_r <= byte_lane_mask_n;
        end
    end
    always_ff @(negedge link_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            wd1_r <= '0;
            wm1_r <= '1;
        end else begin
            wd1_r <= dq_in;
            wm1_r <= byte_lane_mask_n;
        end
    end

    // write pipeline: address held until both words are in
    logic              wr_s1_r;
    logic [ADDR_W-1:0] wa_r;
    always_ff @(posedge link_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            wr_s1_r <= RST_LOW;
            wa_r    <= '0;
        end else begin
            wr_s1_r <= acc_wr;
            if (acc_wr) begin
                wa_r <= addr_r;
            end
        end
    end

    // self-timed array write once the burst pair has arrived
    always_ff @(posedge link_clk) begin
        if (k_rst_n && wr_s1_r) begin
            for (int l = 0; l < LANES; l++) begin
                if (!wm0_r[l]) begin
                    mem_first[wa_r][l*LANE_W +: LANE_W] <= wd0_r[l*LANE_W +: LANE_W];
                end
                if (!wm1_r[l]) begin
                    mem_second[wa_r][l*LANE_W +: LANE_W] <= wd1_r[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // read pipeline: fetch the pair, track stages for both latencies
    logic              rd_s1_r;
    logic              rd_s2_r;
    logic [WORD_W-1:0] rdata0_r;
    logic [WORD_W-1:0] rdata1_r;
    always_ff @(posedge link_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            rd_s1_r  <= RST_LOW;
            rd_s2_r  <= RST_LOW;
            rdata0_r <= '0;
            rdata1_r <= '0;
        end else begin
            rd_s1_r <= acc_rd;
            rd_s2_r <= rd_s1_r;
            if (acc_rd) begin
                rdata0_r <= mem_first[addr_r];
                rdata1_r <= mem_second[addr_r];
            end
        end
    end

    // launch selection per latency mode
    dsp_launch_if #(.W(WORD_W)) lq ();
    always_comb begin
        if (lat_hi) begin
            // first word on the complement edge 2.5 cycles on, second next rise
            lq.neg_ld   = rd_s2_r;
            lq.neg_word = rdata0_r;
            lq.pos_ld   = rd_s2_r;
            lq.pos_word = rdata1_r;
        end else begin
            // first word on the next rise, second on its complement
            lq.pos_ld   = acc_rd;
            lq.pos_word = mem_first[addr_r];
            lq.neg_ld   = rd_s1_r;
            lq.neg_word = rdata1_r;
        end
    end

    // output registers and pin drive
    dsp_ddr_out #(.W(WORD_W)) u_out (
        .link_clk (link_clk),
        .rst_n    (k_rst_n),
        .lq       (lq),
        .q        (dq_out),
        .oe       (dq_oe),
        .vld      (read_valid_flag),
        .echo     (echo_timing_out),
        .echo_n   (echo_timing_out_n)
    );

    // the controller keeps dq_in quiet while dq_oe is high

    // event toggles for the system domain
    logic cmd_tgl_r;
    logic rd_tgl_r;
    always_ff @(posedge link_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            cmd_tgl_r <= RST_LOW;
            rd_tgl_r  <= RST_LOW;
        end else begin
            if (acc_rd || acc_wr) begin
                cmd_tgl_r <= ~cmd_tgl_r;
            end
            if (acc_rd) begin
                rd_tgl_r <= ~rd_tgl_r;
            end
        end
    end

    // crossings into the system clock
    logic cmd_tgl_s;
    logic rd_tgl_s;
    logic lat_s;
    dsp_sync2 #(.RST_VAL(RST_LOW)) u_c_cmd (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (cmd_tgl_r),
        .q      (cmd_tgl_s)
    );
    dsp_sync2 #(.RST_VAL(RST_LOW)) u_c_rd (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (rd_tgl_r),
        .q      (rd_tgl_s)
    );
    dsp_sync2 #(.RST_VAL(RST_LOW)) u_c_lat (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (latency_select),
        .q      (lat_s)
    );

    // toggle edges become one-cycle pulses, all from flops
    logic cmd_d_r;
    logic rd_d_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_d_r  <= RST_LOW;
            rd_d_r   <= RST_LOW;
            cmd_seen <= RST_LOW;
            rd_seen  <= RST_LOW;
            lat_long <= RST_LOW;
        end else begin
            cmd_d_r  <= cmd_tgl_s;
            rd_d_r   <= rd_tgl_s;
            cmd_seen <= cmd_tgl_s ^ cmd_d_r;
            rd_seen  <= rd_tgl_s ^ rd_d_r;
            lat_long <= lat_s;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dsp_pkg.sv
// shared constants for the double-data-rate burst sram port
// assumes nothing beyond a systemverilog compiler
package dsp_pkg;
    // word geometry
    localparam int LANE_W        = 9;       // bits covered by one byte lane mask bit
    localparam int WORD_W_NARROW = 18;      // narrow configuration word width
    localparam int WORD_W_WIDE   = 36;      // wide configuration word width
    localparam int ADDR_W_NARROW = 21;      // 4M words as 2M word pairs
    localparam int ADDR_W_WIDE   = 20;      // 2M words as 1M word pairs
    localparam int BURST_LEN     = 2;       // words per address

    // clocks
    localparam int CLK_PERIOD_PS  = 5000;   // system clock period, 200 MHz
    localparam int LINK_PERIOD_PS = 48000;  // bench link clock period

    // reset values
    localparam logic RST_LOW  = 1'b0;
    localparam logic RST_HIGH = 1'b1;

    // command decoded from the load and read/write pins
    typedef enum logic [1:0] {
        DSP_CMD_NOP   = 2'b00,
        DSP_CMD_READ  = 2'b01,
        DSP_CMD_WRITE = 2'b10
    } dsp_cmd_t;

    // address phase tracker: addresses only on alternate rising edges
    typedef enum logic [0:0] {
        DSP_PH_ADDR = 1'b0,
        DSP_PH_DATA = 1'b1
    } dsp_phase_t;
endpackage

// >>> rtl/dsp_launch_if.sv
// launch requests from the core logic to the double-data-rate output stage
// assumes both ends sit on the link clock domain
`timescale 1ns/1ps
`default_nettype none
interface dsp_launch_if #(
    parameter int W = 18
);
    logic         pos_ld;    // launch a word at the next rising edge
    logic [W-1:0] pos_word;  // word for the rising edge
    logic         neg_ld;    // launch a word at the next complement edge
    logic [W-1:0] neg_word;  // word for the complement edge

    modport src (output pos_ld, output pos_word, output neg_ld, output neg_word);
    modport dst (input pos_ld, input pos_word, input neg_ld, input neg_word);
endinterface
`default_nettype wire

// >>> rtl/dsp_sync2.sv
// two flip-flop level synchroniser
// assumes d is a level that may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none
module dsp_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,     // destination clock
    input  wire logic arst_n,  // asynchronous reset, active low
    input  wire logic d,       // level from another domain
    output logic      q        // synchronised level
);
    logic meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dsp_ddr_out.sv
// double-data-rate output stage: rising and complement edge registers
// assumes link_clk low phase stands for the complement timing input
`timescale 1ns/1ps
`default_nettype none
module dsp_ddr_out #(
    parameter int W = 18
) (
    input  wire logic   link_clk,  // primary timing input
    input  wire logic   rst_n,     // link-domain reset, active low
    dsp_launch_if.dst   lq,        // launch requests
    output logic [W-1:0] q,        // data toward the pins
    output logic        oe,        // pin output enable
    output logic        vld,       // read valid
    output logic        echo,      // echo timing output
    output logic        echo_n     // complementary echo output
);
    import dsp_pkg::*;

    logic [W-1:0] pos_q_r;
    logic [W-1:0] neg_q_r;
    logic         pos_oe_r;
    logic         neg_oe_r;
    logic         pos_echo_r;
    logic         neg_echo_r;

    // rising-edge launch register
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q_r    <= '0;
            pos_oe_r   <= RST_LOW;
            pos_echo_r <= RST_LOW;
        end else begin
            if (lq.pos_ld) begin
                pos_q_r <= lq.pos_word;
            end
            pos_oe_r   <= lq.pos_ld;
            pos_echo_r <= RST_HIGH;
        end
    end

    // complement-edge launch register
    always_ff @(negedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            neg_q_r    <= '0;
            neg_oe_r   <= RST_LOW;
            neg_echo_r <= RST_LOW;
        end else begin
            if (lq.neg_ld) begin
                neg_q_r <= lq.neg_word;
            end
            neg_oe_r   <= lq.neg_ld;
            neg_echo_r <= RST_LOW;
        end
    end

    // edge-select mux: echo shares the data path for tight alignment
    assign q      = link_clk ? pos_q_r : neg_q_r;
    assign oe     = link_clk ? pos_oe_r : neg_oe_r;
    assign vld    = link_clk ? pos_oe_r : neg_oe_r;
    assign echo   = link_clk ? pos_echo_r : neg_echo_r;
    assign echo_n = link_clk ? ~pos_echo_r : ~neg_echo_r;
endmodule
`default_nettype wire

// >>> bench/dsp_sram_port_chk.sv
// checker: pin timing relations of the burst sram port
// assumes bind onto dsp_sram_port with link_clk running free
`timescale 1ns/1ps
`default_nettype none
module dsp_sram_port_chk (
    input wire logic clk,               // system clock
    input wire logic arst_n,            // async reset, active low
    input wire logic link_clk,          // primary timing input
    input wire logic load_n,            // command present
    input wire logic read_nwrite,       // read when high
    input wire logic dq_oe,             // bus drive enable
    input wire logic read_valid_flag,   // read valid
    input wire logic echo_timing_out,   // echo output
    input wire logic echo_timing_out_n, // complementary echo
    input wire logic latency_select,    // latency strap
    input wire logic cmd_seen,          // command pulse
    input wire logic lat_long           // strap seen in clk domain
);
    logic [1:0] up_r;  // link rises since reset, saturating
    logic       acc_r; // command taken at last rise
    logic [3:0] rdh_r; // reads taken at last four rises
    logic [4:0] st_r;  // clk cycles strap held
    logic       ls_r;  // strap one cycle ago
    logic       acc;   // command taken at this rise
    assign acc = (up_r == 2'd3) && !load_n && !acc_r;
    // acceptance tracker on the link side
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            up_r <= 2'h0;
            acc_r <= 1'b0;
            rdh_r <= 4'h0;
        end else begin
            up_r <= (up_r == 2'd3) ? up_r : up_r + 2'd1;
            acc_r <= acc;
            rdh_r <= {rdh_r[2:0], acc && read_nwrite};
        end
    end
    // strap stability counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= 5'h0;
            ls_r <= 1'b0;
        end else begin
            ls_r <= latency_select;
            st_r <= (latency_select != ls_r) ? 5'h0 : (st_r == 5'd31) ? st_r : st_r + 5'd1;
        end
    end
    a_valid_oe_same: assert property (@(posedge clk) disable iff (!arst_n)
        read_valid_flag == dq_oe) else $error("read valid differs from bus enable");
    a_echo_pair: assert property (@(posedge clk) disable iff (!arst_n)
        echo_timing_out_n == !echo_timing_out) else $error("echo outputs not complementary");
    a_echo_follow: assert property (@(posedge clk) disable iff (!arst_n)
        up_r == 2'd3 |-> echo_timing_out == link_clk) else $error("echo not with timing input");
    a_read_lat_short: assert property (@(posedge link_clk) disable iff (!arst_n)
        acc && read_nwrite && !latency_select |-> ##1 !read_valid_flag ##1 read_valid_flag
        ##1 !read_valid_flag) else $error("short latency read window wrong");
    a_read_lat_long: assert property (@(posedge link_clk) disable iff (!arst_n)
        acc && read_nwrite && latency_select |-> ##2 !read_valid_flag ##1 read_valid_flag
        ##1 !read_valid_flag) else $error("long latency read window wrong");
    a_valid_needs_read: assert property (@(posedge link_clk) disable iff (!arst_n)
        read_valid_flag |-> rdh_r != 4'h0) else $error("valid without a taken read");
    a_cmd_pulse_one: assert property (@(posedge clk) disable iff (!arst_n)
        cmd_seen |=> !cmd_seen) else $error("command pulse longer than one cycle");
    a_strap_seen: assert property (@(posedge clk) disable iff (!arst_n)
        st_r == 5'd31 |-> lat_long == latency_select) else $error("strap level not mirrored");
endmodule
`default_nettype wire

// >>> bench/dsp_ctrl_model.sv
// controller model: commands, write words, read capture, bus resolution
// assumes link_clk is made by the bench and runs free
`timescale 1ns/1ps
`default_nettype none
module dsp_ctrl_model #(
    parameter int W  = 18,
    parameter int AW = 4
) (
    input  wire logic                         link_clk,         // primary timing input
    output logic                              load_n,           // command, active low
    output logic                              read_nwrite,      // read when high
    output logic [AW-1:0]                     addr,             // word-pair address
    output logic [W/dsp_pkg::LANE_W-1:0]      byte_lane_mask_n, // lane mask, low writes
    output logic [W-1:0]                      dq_in,            // resolved bus level
    input  wire logic [W-1:0]                 dq_out,           // device drive value
    input  wire logic                         dq_oe,            // device drives bus
    input  wire logic                         read_valid_flag,  // read valid
    input  wire logic                         latency_select    // latency strap
);
    logic [W-1:0] drv = '0;   // controller drive value
    logic [W-1:0] flt = '0;   // last bus level seen
    logic         drv_en = 0; // controller drives bus
    int           hc = 0;     // half cycles seen
    int           clash = 0;  // contention events
    int           pend = 0;   // rises to skip before a write
    logic [W-1:0] rq[$];      // read words captured
    int           rh[$];      // half cycle of each word
    int           ch[$];      // half cycle of each read command
    // device first, then controller, else a drifting level
    assign dq_in = dq_oe ? dq_out : (drv_en ? drv : ~flt);
    initial begin
        load_n = 1'b1;
        read_nwrite = 1'b1;
        addr = '0;
        byte_lane_mask_n = '1;
    end
    // mid half-cycle sampler of read words and contention
    always @(link_clk) begin
        hc = hc + 1;
        #12;
        if (read_valid_flag === 1'b1) begin
            rq.push_back(dq_out);
            rh.push_back(hc);
        end
        if (dq_oe === 1'b1 && drv_en) clash = clash + 1;
        flt = dq_in;
    end
    // one command; write words follow on the next rise and fall
    task automatic issue(input logic rnw, input logic [AW-1:0] a, input logic [W-1:0] w0,
                         input logic [W-1:0] w1, input logic [W/dsp_pkg::LANE_W-1:0] k0,
                         input logic [W/dsp_pkg::LANE_W-1:0] k1, input bit dbl);
        if (!rnw) repeat (pend) begin
            @(posedge link_clk);
            #1;
        end
        load_n = 1'b0;
        read_nwrite = rnw;
        addr = a;
        @(posedge link_clk);
        #1;
        if (rnw) ch.push_back(hc);
        load_n = !dbl; // a load straight after a taken one must be ignored
        read_nwrite = 1'b1;
        drv_en = !rnw;
        drv = w0;
        byte_lane_mask_n = rnw ? '1 : k0;
        @(posedge link_clk);
        #1;
        load_n = 1'b1;
        drv = w1;
        byte_lane_mask_n = rnw ? '1 : k1;
        @(negedge link_clk);
        #1;
        drv_en = 1'b0;
        byte_lane_mask_n = '1;
        pend = (rnw && latency_select) ? 2 : 0; // keep off the bus in the read window
    endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// top bench: sram port, controller model, reference memory and comparisons
// assumes the checker and controller model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dsp_pkg::*;
    localparam int W  = WORD_W_NARROW;
    localparam int AW = 4;
    localparam int NM = W / LANE_W;
    logic          clk, arst_n, link_clk, load_n, read_nwrite, dq_oe, vld, echo, echo_n;
    logic          latency_select, cmd_seen, rd_seen, lat_long;
    logic [AW-1:0] addr;
    logic [NM-1:0] mask_n;
    logic [W-1:0]  dq_in, dq_out;
    logic [W-1:0]  r0 [16];
    logic [W-1:0]  r1 [16];
    logic [W-1:0]  eq[$];
    int            err_total = 0, n_checks = 0, cyc = 0, ncmd = 0, nrd = 0;
    int            seed, ecmd, erd, mode, a, k;

    dsp_sram_port #(.WORD_W(W), .ADDR_W(AW)) dsp_sram_port_inst (
        .clk(clk), .arst_n(arst_n), .link_clk(link_clk), .load_n(load_n),
        .read_nwrite(read_nwrite), .addr(addr), .byte_lane_mask_n(mask_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .read_valid_flag(vld), .echo_timing_out(echo),
        .echo_timing_out_n(echo_n), .latency_select(latency_select), .cmd_seen(cmd_seen),
        .rd_seen(rd_seen), .lat_long(lat_long));
    dsp_ctrl_model #(.W(W), .AW(AW)) dsp_ctrl_model_inst (
        .link_clk(link_clk), .load_n(load_n), .read_nwrite(read_nwrite), .addr(addr),
        .byte_lane_mask_n(mask_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .read_valid_flag(vld), .latency_select(latency_select));

    // system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // link clock, phase apart from the system clock
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #24 link_clk = ~link_clk;
    end
    // pulse counters and run limit
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cmd_seen === 1'b1) ncmd = ncmd + 1;
        if (rd_seen === 1'b1) nrd = nrd + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one command with its reference update
    task automatic op(input logic rnw, input int ad, input bit full, input bit dbl);
        logic [W-1:0]  w0, w1;
        logic [NM-1:0] k0, k1;
        w0 = $random(seed);
        w1 = $random(seed);
        k0 = full ? '0 : NM'($random(seed));
        k1 = full ? '0 : NM'($random(seed));
        ecmd = ecmd + 1;
        if (rnw) begin
            erd = erd + 1;
            eq.push_back(r0[ad]);
            eq.push_back(r1[ad]);
        end else begin
            for (int l = 0; l < NM; l++) begin
                if (!k0[l]) r0[ad][l*LANE_W +: LANE_W] = w0[l*LANE_W +: LANE_W];
                if (!k1[l]) r1[ad][l*LANE_W +: LANE_W] = w1[l*LANE_W +: LANE_W];
            end
        end
        dsp_ctrl_model_inst.issue(rnw, ad[AW-1:0], w0, w1, k0, k1, dbl);
    endtask

    // compare captured words, their half cycles and the pulse counts
    task automatic drain();
        int c, lat;
        repeat (8) @(posedge link_clk);
        lat = latency_select ? 5 : 2;
        chk("word count", eq.size(), dsp_ctrl_model_inst.rq.size());
        while (dsp_ctrl_model_inst.ch.size() > 0 && dsp_ctrl_model_inst.rh.size() > 1
               && eq.size() > 1) begin
            c = dsp_ctrl_model_inst.ch.pop_front();
            for (int j = 0; j < 2; j++) begin
                chk("read word", eq.pop_front(), dsp_ctrl_model_inst.rq.pop_front());
                chk("word half", c + lat + j, dsp_ctrl_model_inst.rh.pop_front());
            end
        end
        chk("commands", ecmd, ncmd);
        chk("reads", erd, nrd);
        chk("contention", 0, dsp_ctrl_model_inst.clash);
        chk("strap", mode, lat_long);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // both latency modes, each behind its own reset
    initial begin
        arst_n = 1'b0;
        latency_select = 1'b0;
        seed = 31;
        for (mode = 0; mode < 2; mode++) begin
            @(posedge clk);
            #1;
            arst_n = 1'b0;
            latency_select = mode[0];
            repeat (12) @(posedge clk);
            repeat (3) @(posedge link_clk);
            @(posedge clk);
            #1;
            arst_n = 1'b1;
            repeat (4) @(posedge link_clk);
            #1;
            ncmd = 0;
            nrd = 0;
            ecmd = 0;
            erd = 0;
            for (a = 0; a < 16; a++) op(1'b0, a, 1'b1, 1'b0);
            repeat (24) begin
                a = $random(seed) & 15;
                k = $random(seed) & 3;
                op(k == 1, a, 1'b0, k == 2);
                if (k == 3) op(1'b1, a, 1'b0, 1'b0);
            end
            for (a = 0; a < 16; a++) op(1'b1, a, 1'b0, a[0]);
            drain();
        end
        summarize();
    end
endmodule

bind dsp_sram_port dsp_sram_port_chk dsp_sram_port_chk_inst (
    .clk(clk), .arst_n(arst_n), .link_clk(link_clk), .load_n(load_n),
    .read_nwrite(read_nwrite), .dq_oe(dq_oe), .read_valid_flag(read_valid_flag),
    .echo_timing_out(echo_timing_out), .echo_timing_out_n(echo_timing_out_n),
    .latency_select(latency_select), .cmd_seen(cmd_seen), .lat_long(lat_long));
`default_nettype wire
